// ---- rtl/trace_cfg_regs.vh ----
// Behaviour
// - Capability bit 27 reports reduced counter 1 from the later version, else zero.
// - Bit 26 reports virtualization; enables VM comparator and VIRTUAL_MACHINE_IDENTIFIER controls.
// - Bit 25 reports timestamps generated for every barrier operation.
// - Bit 24 reports barriers treated as waypoints; zero forbids both sides.
// - Bit 23 reports return stack; only then return-stack enable is writable.
// - Bit 22 reports timestamping; gates timestamp event register and enable.
// - Bit 21 reports presence of the sampling-behaviour register.
// - Bit 20 reports start/stop block can use watchpoint inputs.
// - Field 19:16 reports watchpoint input count, zero to eight.
// - Field 15:13 reports instrumentation resources, at most four.
// - Bits 2:0 report selector count; missing selectors read zero, ignore writes.
// - Selector 1 sits in bits 7:0 of the selection register.
// - Start/stop bits 23:16 choose stop inputs, bit 16 is input 1.
// - Start/stop bits 7:0 choose start inputs, bit 0 is input 1.
// - With no watchpoint inputs the start/stop register reads zero, ignores writes.
// - Sampling bit 0 pulses one sample, 1 latches until before next sample; here the held value clears one cycle after the sample point.
// - Timestamp event holds 17 bits; function 16:14; event inserts a timestamp.
// - Timestamp event register reads zero and ignores writes without timestamping.
// - Auxiliary control register is implementation-defined and resets to zero.
// - Seven-bit source identifier drives the trace bus; resets to zero.
// - Identifier in bits 6:0, bits 31:7 reserved.
`ifndef TRACE_CFG_REGS_VH
`define TRACE_CFG_REGS_VH
`define CFG_EXT_OFFSET     6'h00
`define EXT_SEL_OFFSET     6'h04
`define START_STOP_OFFSET  6'h08
`define SAMPLING_OFFSET    6'h0c
`define TS_EVENT_OFFSET    6'h10
`define AUX_CTRL_OFFSET    6'h14
`define TRACE_ID_OFFSET    6'h18
`define MAIN_CTRL_OFFSET   6'h1c
`define VM_CMP_OFFSET      6'h20
`define CFG_RED_CNT_BIT    27
`define CFG_VIRT_BIT       26
`define CFG_TS_BARRIER_BIT 25
`define CFG_WAYPOINT_BIT   24
`define CFG_RSTACK_BIT     23
`define CFG_TS_BIT         22
`define CFG_SAMPLING_BIT   21
`define CFG_SS_WP_BIT      20
`define CFG_RAO_BIT        12
`define MAIN_RSTACK_BIT    0
`define MAIN_TS_BIT        1
`define MAIN_VIRTUAL_MACHINE_IDENTIFIER_BIT      2
`define TS_EVENT_WIDTH     17
`define TRACE_ID_WIDTH     7
`define ALWAYS_TRUE_EVENT  17'h0006f
`define RESET_ZERO         32'h00000000
`endif

// ---- rtl/watchpoint_sampler.v ----
`timescale 1ns/100ps
`include "trace_cfg_regs.vh"
module watchpoint_sampler #(
   parameter N = 8
) (
   input  wire         ref_clk,
   input  wire         rst_n,
   input  wire         sample_pt,
   input  wire [N-1:0] hold_mode,
   input  wire [N-1:0] wp_in,
   output reg  [N-1:0] wp_out
);
   reg [N-1:0] held_q;
   genvar i;
   generate
      for (i = 0; i < N; i = i + 1) begin : g_wp
         // Held value stays for one cycle after the sample point, then clears to zero
         always @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               held_q[i] <= 1'b0;
               wp_out[i] <= 1'b0;
            end else if (sample_pt) begin
               held_q[i] <= wp_in[i] & hold_mode[i];
               wp_out[i] <= wp_in[i];
            end else begin
               wp_out[i] <= held_q[i];
               held_q[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule

// ---- rtl/trace_macrocell_config_regs.v ----
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "trace_cfg_regs.vh"
module trace_macrocell_config_regs #(
   parameter       LATER_VERSION = 1,
   parameter       RED_COUNTER   = 0,
   parameter       VIRT_IMPL     = 1,
   parameter       TS_BARRIER    = 1,
   parameter       WAYPOINT_BAR  = 1,
   parameter       RSTACK_IMPL   = 1,
   parameter       TS_IMPL       = 1,
   parameter       SAMPLING_IMPL = 1,
   parameter       SS_WP_USE     = 1,
   parameter [3:0] NUM_WP        = 4'h8,
   parameter [2:0] NUM_INSTR     = 3'h4,
   parameter [2:0] NUM_EXT_SEL   = 3'h4
) (
   input  wire        ref_clk,
   input  wire        rst_n,
   input  wire [5:0]  addr,
   input  wire [31:0] wdata,
   input  wire        wr_en,
   input  wire        rd_en,
   output reg  [31:0] rdata,
   input  wire        sample_pt,
   input  wire [7:0]  wp_in,
   output reg  [7:0]  wp_sampled,
   output reg  [7:0]  trace_start,
   output reg  [7:0]  trace_stop,
   input  wire        ts_event_hit,
   output reg         ts_insert,
   output reg  [16:0] ts_event_def,
   output reg  [31:0] ext_sel,
   output reg  [31:0] aux_ctrl,
   output reg  [6:0]  trace_id,
   output reg         rstack_en,
   output reg         ts_en,
   output reg         virtual_machine_identifier_en,
   output reg  [7:0]  vm_cmp_value,
   output reg         barrier_waypoint,
   output reg         barrier_ts
);
   wire        later = (LATER_VERSION != 0);
   wire        virt = later && (VIRT_IMPL != 0);
   wire        ts_ok = (TS_IMPL != 0);
   wire        wp_ok = (NUM_WP != 4'h0);
   wire [31:0] cfg_ext;
   wire [31:0] ext_mask;
   wire [7:0]  wp_mask;
   wire [7:0]  sampled_raw;
   wire [7:0]  hold_mode;

   reg [31:0] ext_sel_q;
   reg [31:0] ss_q;
   reg [7:0]  samp_q;
   reg [16:0] tsev_q;
   reg [31:0] aux_q;
   reg [6:0]  id_q;
   reg [2:0]  main_q;
   reg [7:0]  vm_q;
   reg [31:0] rd_d;

   function sel;
      input [5:0] a;
      input [5:0] off;
      begin
         sel = (a == off);
      end
   endfunction

   assign cfg_ext = {2'b00,
                     1'b0, 1'b0,
                     later && (RED_COUNTER != 0),
                     virt,
                     (TS_BARRIER != 0),
                     (WAYPOINT_BAR != 0),
                     (RSTACK_IMPL != 0),
                     ts_ok,
                     (SAMPLING_IMPL != 0),
                     (SS_WP_USE != 0),
                     NUM_WP,
                     NUM_INSTR,
                     1'b1,
                     9'h000,
                     NUM_EXT_SEL};

   // Selector byte k exists only when k is below the reported count
   genvar k;
   generate
      for (k = 0; k < 4; k = k + 1) begin : g_ext
         assign ext_mask[8*k+7:8*k] = (NUM_EXT_SEL > k) ? 8'hff : 8'h00;
      end
      for (k = 0; k < 8; k = k + 1) begin : g_wpm
         assign wp_mask[k] = (NUM_WP > k);
      end
   endgenerate

   assign hold_mode = (SAMPLING_IMPL != 0) ? samp_q : 8'h00;

   watchpoint_sampler #(
      .N (8)
   ) u_sampler (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .sample_pt (sample_pt),
      .hold_mode (hold_mode),
      .wp_in     (wp_in & wp_mask),
      .wp_out    (sampled_raw)
   );

   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ext_sel_q <= `RESET_ZERO;
         ss_q      <= `RESET_ZERO;
         samp_q    <= 8'h00;
         tsev_q    <= 17'h00000;
         aux_q     <= `RESET_ZERO;
         id_q      <= 7'h00;
         main_q    <= 3'h0;
         vm_q      <= 8'h00;
      end else if (wr_en) begin
         if (sel(addr, `EXT_SEL_OFFSET))
            ext_sel_q <= wdata & ext_mask;
         if (sel(addr, `START_STOP_OFFSET) && wp_ok)
            ss_q <= wdata & {8'h00, wp_mask, 8'h00, wp_mask};
         if (sel(addr, `SAMPLING_OFFSET) && (SAMPLING_IMPL != 0))
            samp_q <= wdata[7:0];
         if (sel(addr, `TS_EVENT_OFFSET) && ts_ok)
            tsev_q <= wdata[16:0];
         if (sel(addr, `AUX_CTRL_OFFSET))
            aux_q <= wdata;
         if (sel(addr, `TRACE_ID_OFFSET))
            id_q <= wdata[6:0];
         if (sel(addr, `MAIN_CTRL_OFFSET)) begin
            main_q[`MAIN_RSTACK_BIT] <= wdata[`MAIN_RSTACK_BIT] & (RSTACK_IMPL != 0);
            main_q[`MAIN_TS_BIT]     <= wdata[`MAIN_TS_BIT] & ts_ok;
            main_q[`MAIN_VIRTUAL_MACHINE_IDENTIFIER_BIT]   <= wdata[`MAIN_VIRTUAL_MACHINE_IDENTIFIER_BIT] & virt;
         end
         if (sel(addr, `VM_CMP_OFFSET) && virt)
            vm_q <= wdata[7:0];
      end
   end

   always @* begin
      rd_d = `RESET_ZERO;
      case (addr)
         `CFG_EXT_OFFSET:    rd_d = cfg_ext;
         `EXT_SEL_OFFSET:    rd_d = ext_sel_q;
         `START_STOP_OFFSET: rd_d = ss_q;
         `SAMPLING_OFFSET:   rd_d = {24'h000000, samp_q};
         `TS_EVENT_OFFSET:   rd_d = {15'h0000, tsev_q};
         `AUX_CTRL_OFFSET:   rd_d = aux_q;
         `TRACE_ID_OFFSET:   rd_d = {25'h0000000, id_q};
         `MAIN_CTRL_OFFSET:  rd_d = {29'h00000000, main_q};
         `VM_CMP_OFFSET:     rd_d = {24'h000000, vm_q};
         default:            rd_d = `RESET_ZERO;
      endcase
   end

   // Outputs registered; read data stands one cycle after the strobe only
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata            <= `RESET_ZERO;
         wp_sampled       <= 8'h00;
         trace_start      <= 8'h00;
         trace_stop       <= 8'h00;
         ts_insert        <= 1'b0;
         ts_event_def     <= 17'h00000;
         ext_sel          <= `RESET_ZERO;
         aux_ctrl         <= `RESET_ZERO;
         trace_id         <= 7'h00;
         rstack_en        <= 1'b0;
         ts_en            <= 1'b0;
         virtual_machine_identifier_en          <= 1'b0;
         vm_cmp_value     <= 8'h00;
         barrier_waypoint <= 1'b0;
         barrier_ts       <= 1'b0;
      end else begin
         rdata            <= rd_en ? rd_d : `RESET_ZERO;
         wp_sampled       <= sampled_raw;
         trace_start      <= (SS_WP_USE != 0) ? (sampled_raw & ss_q[7:0]) : 8'h00;
         trace_stop       <= (SS_WP_USE != 0) ? (sampled_raw & ss_q[23:16]) : 8'h00;
         ts_insert        <= ts_event_hit & ts_ok;
         ts_event_def     <= tsev_q;
         ext_sel          <= ext_sel_q;
         aux_ctrl         <= aux_q;
         trace_id         <= id_q;
         rstack_en        <= main_q[`MAIN_RSTACK_BIT];
         ts_en            <= main_q[`MAIN_TS_BIT];
         virtual_machine_identifier_en          <= main_q[`MAIN_VIRTUAL_MACHINE_IDENTIFIER_BIT];
         vm_cmp_value     <= vm_q;
         barrier_waypoint <= (WAYPOINT_BAR != 0);
         barrier_ts       <= (TS_BARRIER != 0) & main_q[`MAIN_TS_BIT];
      end
   end
endmodule

// ---- tb/trace_cfg_chk.sv ----
`timescale 1ns/100ps
`include "trace_cfg_regs.vh"
module trace_cfg_chk (
   input wire        ref_clk,
   input wire        rst_n,
   input wire [5:0]  addr,
   input wire [31:0] wdata,
   input wire        wr_en,
   input wire        rd_en,
   input wire [31:0] rdata,
   input wire        sample_pt,
   input wire [7:0]  wp_in,
   input wire [7:0]  wp_sampled,
   input wire        ts_event_hit,
   input wire        ts_insert,
   input wire [31:0] aux_ctrl,
   input wire [6:0]  trace_id,
   input wire        barrier_waypoint,
   input wire        barrier_ts,
   input wire        ts_en
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence wr_at(off);
      wr_en && addr == off;
   endsequence
   a_read_idle_zero: assert property (!$past(rd_en) |-> rdata == 32'h0)
      else $error("read data not zero outside read slot");
   a_trace_id_copy: assert property (wr_at(`TRACE_ID_OFFSET) ##2 1 |-> trace_id == $past(wdata[6:0], 2))
      else $error("trace id output does not follow write");
   a_aux_copy: assert property (wr_at(`AUX_CTRL_OFFSET) ##2 1 |-> aux_ctrl == $past(wdata, 2))
      else $error("aux control output does not follow write");
   a_ts_insert_follow: assert property (1'b1 |=> ts_insert == $past(ts_event_hit))
      else $error("timestamp insert not one cycle after event");
   a_sample_capture: assert property (sample_pt |-> ##2 wp_sampled == $past(wp_in, 2))
      else $error("sampled inputs do not match inputs at sample point");
   a_cfg_fixed_bits: assert property (rd_en && addr == `CFG_EXT_OFFSET |=> rdata[12:3] == 10'h200)
      else $error("config extension fixed bits wrong");
   a_unmapped_zero: assert property (rd_en && addr == 6'h3c |=> rdata == 32'h0)
      else $error("unmapped read not zero");
   // Barrier timestamps only follow the timestamp enable, waypoint level never moves
   a_capab_stable: assert property ($past(rst_n, 2) |-> $stable(barrier_waypoint) && barrier_ts == ts_en)
      else $error("capability level changed");
endmodule
bind trace_macrocell_config_regs trace_cfg_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
   .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_pt(sample_pt), .wp_in(wp_in),
   .wp_sampled(wp_sampled), .ts_event_hit(ts_event_hit), .ts_insert(ts_insert), .aux_ctrl(aux_ctrl),
   .trace_id(trace_id), .barrier_waypoint(barrier_waypoint), .barrier_ts(barrier_ts), .ts_en(ts_en));

// ---- tb/trace_macrocell_config_regs_test.sv ----
`timescale 1ns/100ps
`include "trace_cfg_regs.vh"
module trace_macrocell_config_regs_test;
   logic        ref_clk, rst_n, wr_en, rd_en, sample_pt, ts_event_hit, rd_q;
   logic        rstack_en, ts_en, virtual_machine_identifier_en, barrier_waypoint, barrier_ts, ts_insert;
   logic [5:0]  addr;
   logic [31:0] wdata, rdata, w, ext_sel, aux_ctrl;
   logic [7:0]  wp_in, wp_sampled, trace_start, trace_stop, vm_cmp_value, s0, s1;
   logic [16:0] ts_event_def;
   logic [6:0]  trace_id;
   logic [31:0] exp_q[$], msk_q[$], exp2_q[$];
   logic [31:0] rdata2, mk;
   logic        ts_en2, virtual_machine_identifier_en2;
   logic [5:0]  offs[7] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20};
   logic [31:0] msks[7] = '{32'hffffffff, 32'h00ff00ff, 32'h000000ff, 32'h0001ffff, 32'hffffffff,
                            32'h0000007f, 32'h000000ff};
   logic [31:0] msks2[7] = '{32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000, 32'hffffffff,
                             32'h0000007f, 32'h00000000};
   int          fails = 0, checks = 0, i;
   trace_macrocell_config_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sample_pt(sample_pt), .wp_in(wp_in),
      .wp_sampled(wp_sampled), .trace_start(trace_start), .trace_stop(trace_stop),
      .ts_event_hit(ts_event_hit), .ts_insert(ts_insert), .ts_event_def(ts_event_def), .ext_sel(ext_sel),
      .aux_ctrl(aux_ctrl), .trace_id(trace_id), .rstack_en(rstack_en), .ts_en(ts_en), .virtual_machine_identifier_en(virtual_machine_identifier_en),
      .vm_cmp_value(vm_cmp_value), .barrier_waypoint(barrier_waypoint), .barrier_ts(barrier_ts));
   // Stripped build: absent features must read zero and drop writes
   trace_macrocell_config_regs #(.LATER_VERSION(0), .TS_BARRIER(0), .TS_IMPL(0), .SAMPLING_IMPL(0),
      .SS_WP_USE(0), .NUM_WP(4'h0), .NUM_EXT_SEL(3'h0)) DUT_min (.ref_clk(ref_clk), .rst_n(rst_n),
      .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata2), .sample_pt(sample_pt),
      .wp_in(8'h00), .wp_sampled(), .trace_start(), .trace_stop(), .ts_event_hit(1'b0), .ts_insert(),
      .ts_event_def(), .ext_sel(), .aux_ctrl(), .trace_id(), .rstack_en(), .ts_en(ts_en2),
      .virtual_machine_identifier_en(virtual_machine_identifier_en2), .vm_cmp_value(), .barrier_waypoint(), .barrier_ts());
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // Each task drives both strobes once, so calls may follow back to back
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      wr_en <= 1'b1; rd_en <= 1'b0; addr <= a; wdata <= d;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m, input logic [31:0] e2);
      rd_en <= 1'b1; wr_en <= 1'b0; addr <= a;
      exp_q.push_back(e); msk_q.push_back(m); exp2_q.push_back(e2);
      @(posedge ref_clk);
   endtask
   task automatic idle;
      wr_en <= 1'b0; rd_en <= 1'b0;
      @(posedge ref_clk);
   endtask
   always @(posedge ref_clk) begin
      rd_q <= rd_en;
      if (rd_q && exp_q.size() > 0) begin
         mk = msk_q.pop_front();
         chk("rdata", exp_q.pop_front(), rdata & mk);
         chk("rdata_min", exp2_q.pop_front(), rdata2 & mk);
      end
      if (!rst_n) begin
         sample_pt <= 1'b0;
         ts_event_hit <= 1'b0;
      end else begin
         sample_pt <= ~sample_pt;
         ts_event_hit <= 1'($urandom);
      end
   end
   initial begin
      #500us;
      fails++;
      report_and_stop;
   end
   initial begin
      rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 6'h0; wdata = 32'h0;
      wp_in = 8'h00;
      void'($urandom(86));
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      wp_in <= 8'($urandom);
      @(posedge ref_clk);
      rd(`AUX_CTRL_OFFSET, 32'h0, '1, 32'h0);
      rd(`TRACE_ID_OFFSET, 32'h0, '1, 32'h0);
      // Full build and stripped build differ in bits 26:25, 22:20, 19:16 and 2:0
      rd(`CFG_EXT_OFFSET, 32'h07f89004, 32'h0fffffff, 32'h01809000);
      rd(`CFG_EXT_OFFSET, 32'h07f89004, 32'h0fffffff, 32'h01809000);
      rd(`CFG_EXT_OFFSET, 32'h07f89004, 32'h0fffffff, 32'h01809000);
      for (i = 0; i < 7; i++) begin
         w = $urandom;
         if (offs[i] == `TS_EVENT_OFFSET && w[16:0] == `ALWAYS_TRUE_EVENT) w = w ^ 32'h00000001;
         wr(offs[i], w);
         rd(offs[i], w & msks[i], '1, w & msks2[i]);
         wr(offs[i], '1);
         rd(offs[i], msks[i], '1, msks2[i]);
      end
      wr(6'h3c, '1);
      rd(6'h3c, 32'h0, '1, 32'h0);
      wr(`TRACE_ID_OFFSET, 32'hffffff55);
      wr(`TS_EVENT_OFFSET, 32'hfffdc0a5);
      wr(`MAIN_CTRL_OFFSET, 32'h7);
      repeat (2) idle;
      chk("trace_id", 32'h55, 32'(trace_id));
      chk("ts_event_def", 32'h1c0a5, 32'(ts_event_def));
      chk("ext_sel", 32'hffffffff, ext_sel);
      chk("main_ctrl", 32'h7, {29'h0, virtual_machine_identifier_en, ts_en, rstack_en});
      chk("barrier", 32'h3, {30'h0, barrier_ts, barrier_waypoint});
      chk("aux_ctrl", 32'hffffffff, aux_ctrl);
      chk("vm_cmp", 32'h000000ff, 32'(vm_cmp_value));
      chk("main_min", 32'h0, {30'h0, virtual_machine_identifier_en2, ts_en2});
      // Held mode first: a steady input must stay visible between samples
      wr(`START_STOP_OFFSET, 32'h00f0000f);
      wr(`SAMPLING_OFFSET, 32'h000000ff);
      wp_in <= 8'ha5;
      repeat (8) idle;
      s0 = wp_sampled;
      @(posedge ref_clk);
      s1 = wp_sampled;
      chk("held", 32'ha5, 32'(s0 & s1));
      chk("trace_start", 32'h05, 32'(trace_start));
      chk("trace_stop", 32'ha0, 32'(trace_stop));
      wr(`SAMPLING_OFFSET, 32'h0);
      repeat (8) idle;
      s0 = wp_sampled;
      @(posedge ref_clk);
      s1 = wp_sampled;
      chk("pulse_or", 32'ha5, 32'(s0 | s1));
      chk("pulse_and", 32'h0, 32'(s0 & s1));
      repeat (3) idle;
      report_and_stop;
   end
endmodule
